// ---- bench/pxg_crossbar_gpio_chk.sv ----
// Assertion checker for the port crossbar and GPIO block
`timescale 1ns/1ps
`include "pxg_defines.vh"
module pxg_chk (
   input wire CLK_I,
   input wire RST_N_I,
   input wire [5:0] AVS_ADDRESS_I,
   input wire AVS_READ_I,
   input wire AVS_WRITE_I,
   input wire [31:0] AVS_WRITEDATA_I,
   input wire [3:0] AVS_BYTEENABLE_I,
   input wire [31:0] AVS_READDATA_O,
   input wire AVS_WAITREQUEST_O,
   input wire [31:0] PIN_I,
   input wire [31:0] PIN_O,
   input wire [31:0] PIN_OE_O,
   input wire [16:0] PERIPH_OUT_I,
   input wire [16:0] PERIPH_IN_O,
   input wire UART_A_MODE0_I,
   input wire UART_B_MODE0_I
);
   logic en_q;
   logic en_d;
   logic wr_seen;
   wire wr_done = AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_BYTEENABLE_I[0];
   wire rd_done = AVS_READ_I && !AVS_WAITREQUEST_O;
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   // Global enable as last written
   always @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         en_q <= 1'b0;
         en_d <= 1'b0;
         wr_seen <= 1'b0;
      end else begin
         if (wr_done && AVS_ADDRESS_I == `PXG_OFS_XCFG2) begin
            en_q <= AVS_WRITEDATA_I[`PXG_XCFG2_GLOBAL_EN];
         end
         en_d <= en_q;
         wr_seen <= wr_seen | wr_done;
      end
   end
   sequence s_req; $rose(AVS_READ_I || AVS_WRITE_I); endsequence
   sequence s_ack; AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O; endsequence
   sequence s_quiet;
      (!wr_done && $stable(PERIPH_OUT_I) && $stable({UART_A_MODE0_I, UART_B_MODE0_I}))[*2];
   endsequence
   property p_req_wait; s_req |-> s_ack; endproperty
   property p_idle; !(AVS_READ_I || AVS_WRITE_I) |-> !AVS_WAITREQUEST_O; endproperty
   property p_one_wait; AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O; endproperty
   property p_unmapped; rd_done && AVS_ADDRESS_I[1:0] != 2'b00 |-> AVS_READDATA_O == 32'h0;
   endproperty
   property p_rd_upper; rd_done && AVS_ADDRESS_I < 6'h30 |-> AVS_READDATA_O[31:8] == 24'h0;
   endproperty
   property p_off; !en_q && !en_d |-> PIN_OE_O == 32'h0; endproperty
   property p_boot; !wr_seen |-> PIN_OE_O == 32'h0 && PIN_O == 32'h0; endproperty
   property p_periph_idle; !en_q && !en_d |-> PERIPH_IN_O == 17'h1ffff; endproperty
   property p_pins_hold; s_quiet |=> $stable(PIN_OE_O) && $stable(PIN_O); endproperty
   a_req_wait: assert property (p_req_wait) else $error("wait cycle wrong");
   a_idle: assert property (p_idle) else $error("wait while idle");
   a_one_wait: assert property (p_one_wait) else $error("wait too long");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not 0");
   a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
   a_off: assert property (p_off) else $error("driver on while off");
   a_boot: assert property (p_boot) else $error("driver on after reset");
   a_periph_idle: assert property (p_periph_idle) else $error("input routed while off");
   a_pins_hold: assert property (p_pins_hold) else $error("pin moved without cause");
endmodule // pxg_chk

bind pxg_crossbar_gpio pxg_chk u_chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
   .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
   .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I),
   .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .PIN_I(PIN_I),
   .PIN_O(PIN_O), .PIN_OE_O(PIN_OE_O), .PERIPH_OUT_I(PERIPH_OUT_I), .PERIPH_IN_O(PERIPH_IN_O),
   .UART_A_MODE0_I(UART_A_MODE0_I), .UART_B_MODE0_I(UART_B_MODE0_I));

// ---- bench/pxg_pin_model.sv ----
// External devices wired to the port pins
`timescale 1ns/1ps
module pxg_pin_model (
   input wire clk_i,
   input wire [31:0] pin_o_i,
   input wire [31:0] pin_oe_i,
   input wire [31:0] ext_val_i,
   input wire [31:0] ext_oe_i,
   output wire [31:0] pin_i_o
);
   logic [31:0] float_reg = 32'h5a5a5a5a;
   wire [31:0] low = (pin_oe_i & ~pin_o_i) | (ext_oe_i & ~ext_val_i);
   // Undriven lines keep changing so a stale level is never read
   always @(posedge clk_i) begin
      float_reg <= ~float_reg;
   end
   // Any low driver wins on the wire
   assign pin_i_o = ~low & (pin_oe_i | ext_oe_i | float_reg);
endmodule // pxg_pin_model

// ---- bench/test_port_io_crossbar_gpio.sv ----
// Self-checking bench for the port crossbar and GPIO block
`timescale 1ns/1ps
`include "pxg_defines.vh"
module test_port_io_crossbar_gpio;
   logic CLK_I = 1'b0;
   logic RST_N_I = 1'b0;
   logic [5:0] AVS_ADDRESS_I = 6'h00;
   logic AVS_READ_I = 1'b0;
   logic AVS_WRITE_I = 1'b0;
   logic [31:0] AVS_WRITEDATA_I = 32'h0;
   logic [3:0] AVS_BYTEENABLE_I = 4'h1;
   logic [16:0] PERIPH_OUT_I = 17'h0;
   logic UART_A_MODE0_I = 1'b0;
   logic UART_B_MODE0_I = 1'b0;
   logic [31:0] ext_val = 32'h0;
   logic [31:0] ext_oe = 32'h0;
   wire [31:0] AVS_READDATA_O;
   wire AVS_WAITREQUEST_O;
   wire [31:0] PIN_I;
   wire [31:0] PIN_O;
   wire [31:0] PIN_OE_O;
   wire [16:0] PERIPH_IN_O;
   integer bad_count = 0;
   integer checked = 0;
   always #50 CLK_I = ~CLK_I;
   pxg_crossbar_gpio DUT (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
      .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
      .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .AVS_READDATA_O(AVS_READDATA_O),
      .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .PIN_I(PIN_I), .PIN_O(PIN_O), .PIN_OE_O(PIN_OE_O),
      .PERIPH_OUT_I(PERIPH_OUT_I), .PERIPH_IN_O(PERIPH_IN_O), .UART_A_MODE0_I(UART_A_MODE0_I),
      .UART_B_MODE0_I(UART_B_MODE0_I));
   pxg_pin_model u_pins (.clk_i(CLK_I), .pin_o_i(PIN_O), .pin_oe_i(PIN_OE_O),
      .ext_val_i(ext_val), .ext_oe_i(ext_oe), .pin_i_o(PIN_I));
   task give_verdict;
      begin
         $display("comparisons %0d mismatches %0d", checked, bad_count);
         if (bad_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
         end else begin
            $display("SIMULATION FAILED");
         end
         $finish;
      end
   endtask
   task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("mismatch read at %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task automatic cmp_pin(input logic [31:0] got, input logic [31:0] exp);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("mismatch pins at %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task automatic bus_wr(input logic [5:0] a, input logic [31:0] d);
      begin
         @(posedge CLK_I);
         AVS_ADDRESS_I <= a;
         AVS_WRITEDATA_I <= d;
         AVS_WRITE_I <= 1'b1;
         @(posedge CLK_I);
         while (AVS_WAITREQUEST_O !== 1'b0) @(posedge CLK_I);
         AVS_WRITE_I <= 1'b0;
      end
   endtask
   task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
      logic [31:0] d;
      begin
         @(posedge CLK_I);
         AVS_ADDRESS_I <= a;
         AVS_READ_I <= 1'b1;
         @(posedge CLK_I);
         while (AVS_WAITREQUEST_O !== 1'b0) @(posedge CLK_I);
         d = AVS_READDATA_O;
         AVS_READ_I <= 1'b0;
         cmp_rd(d, exp);
      end
   endtask
   task settle;
      begin
         repeat (2) @(posedge CLK_I);
         @(negedge CLK_I);
      end
   endtask
   initial begin
      repeat (3000) @(posedge CLK_I);
      bad_count = bad_count + 1;
      give_verdict;
   end
   initial begin
      repeat (2) @(posedge CLK_I);
      RST_N_I <= 1'b1;
      rd_chk(`PXG_OFS_MODE0, 32'h0);
      rd_chk(`PXG_OFS_XCFG2, 32'h0);
      rd_chk(`PXG_OFS_P1IN, 32'hff);
      rd_chk(`PXG_OFS_LATCH0, 32'hffffffff);
      rd_chk(6'h02, 32'h0);
      settle;
      cmp_pin(PIN_OE_O, 32'h0);
      $display("test reset done");
      bus_wr(`PXG_OFS_DATA0, 32'h0);
      bus_wr(`PXG_OFS_MODE0, 32'hff);
      settle;
      cmp_pin(PIN_OE_O, 32'h0);
      cmp_pin({15'h0, PERIPH_IN_O}, 32'h1ffff);
      $display("test crossbar off done");
      bus_wr(`PXG_OFS_XCFG2, 32'h40);
      settle;
      cmp_pin(PIN_OE_O, 32'hff);
      cmp_pin(PIN_O, 32'h0);
      bus_wr(`PXG_OFS_MODE0, 32'h0f);
      bus_wr(`PXG_OFS_DATA0, 32'haa);
      settle;
      cmp_pin(PIN_OE_O, 32'h5f);
      cmp_pin(PIN_O, 32'h0a);
      bus_wr(`PXG_OFS_BITACC, 32'h104);
      bus_wr(`PXG_OFS_BITACC, 32'h001);
      settle;
      cmp_pin(PIN_OE_O, 32'h4f);
      cmp_pin(PIN_O, 32'h08);
      $display("test gpio drive done");
      @(posedge CLK_I);
      ext_val <= 32'h003cff00;
      ext_oe <= 32'h00ffff00;
      settle;
      rd_chk(`PXG_OFS_DATA2, 32'h3c);
      rd_chk(`PXG_OFS_LATCH0, 32'hffffffb8);
      bus_wr(`PXG_OFS_P1IN, 32'hfe);
      rd_chk(`PXG_OFS_DATA1, 32'hfe);
      $display("test pin read done");
      @(posedge CLK_I);
      PERIPH_OUT_I <= 17'h5;
      ext_val <= 32'h003cff04;
      ext_oe <= 32'h00ffff06;
      bus_wr(`PXG_OFS_MODE0, 32'hff);
      bus_wr(`PXG_OFS_SERIAL, 32'h3);
      settle;
      cmp_pin(PIN_OE_O, 32'hf9);
      cmp_pin(PIN_O, 32'hb1);
      cmp_pin({30'h0, PERIPH_IN_O[5], PERIPH_IN_O[1]}, 32'h2);
      rd_chk(6'h38, 32'hf);
      bus_wr(`PXG_OFS_DATA0, 32'h0f);
      settle;
      cmp_pin(PIN_O, 32'h01);
      @(posedge CLK_I);
      UART_A_MODE0_I <= 1'b1;
      settle;
      cmp_pin(PIN_OE_O, 32'hfb);
      bus_wr(`PXG_OFS_XCFG1, 32'hff);
      bus_wr(`PXG_OFS_XCFG2, 32'h5d);
      rd_chk(6'h38, 32'h0003feff);
      @(posedge CLK_I);
      PERIPH_OUT_I <= 17'h25;
      UART_B_MODE0_I <= 1'b1;
      settle;
      cmp_pin(PIN_OE_O, 32'h0001005b);
      cmp_pin(PIN_O, 32'h00000001);
      bus_wr(`PXG_OFS_XCFG2, 32'h1d);
      settle;
      cmp_pin(PIN_OE_O, 32'h0);
      rd_chk(6'h38, 32'h0);
      $display("test crossbar done");
      give_verdict;
   end
endmodule // test_port_io_crossbar_gpio

// ---- hw/pxg_crossbar_gpio.v ----
// Port crossbar and GPIO top with Avalon-MM register slave
`timescale 1ns/1ps
`include "pxg_defines.vh"
module pxg_crossbar_gpio (
   input wire CLK_I,
   input wire RST_N_I,
   input wire [5:0] AVS_ADDRESS_I,
   input wire AVS_READ_I,
   input wire AVS_WRITE_I,
   input wire [31:0] AVS_WRITEDATA_I,
   input wire [3:0] AVS_BYTEENABLE_I,
   output wire [31:0] AVS_READDATA_O,
   output wire AVS_WAITREQUEST_O,
   input wire [31:0] PIN_I,
   output wire [31:0] PIN_O,
   output wire [31:0] PIN_OE_O,
   input wire [16:0] PERIPH_OUT_I,
   output wire [16:0] PERIPH_IN_O,
   input wire UART_A_MODE0_I,
   input wire UART_B_MODE0_I
);
   reg [7:0] data_reg [0:3];
   reg [7:0] mode_reg [0:3];
   reg [7:0] port1_input_mode_reg;
   reg [7:0] serial_enable_reg;
   reg [7:0] crossbar_config_one_reg;
   reg [7:0] crossbar_config_two_reg;
   reg ack_reg;
   reg ack_next;
   reg [31:0] readdata_reg;
   reg [31:0] readdata_next;
   reg [31:0] pin_o_reg;
   reg [31:0] pin_oe_reg;
   reg [16:0] periph_in_reg;
   reg [16:0] periph_in_next;
   reg [16:0] sig_en;
   reg [159:0] owner_flat;
   reg [31:0] mapped;
   reg [31:0] periph_out_dir;
   reg [31:0] periph_val;
   reg [31:0] force_od;
   reg [31:0] pin_read;
   reg found;
   reg [4:0] own;
   integer p;
   integer j;
   integer nxt;
   integer k;
   integer m;
   wire [31:0] data_flat;
   wire [31:0] mode_flat;
   wire [31:0] analog_pins;
   wire [31:0] drv_val;
   wire [31:0] drv_oe;
   wire crossbar_global_enable;
   wire req;
   wire wr_fire;
   wire lane0;
   wire [4:0] bit_pin;
   wire [1:0] bit_port;
   wire [2:0] bit_idx;

   // Returns 1 when a signal index is driven by its peripheral
   function sig_is_output;
      input [4:0] s;
      input mode0_a;
      input mode0_b;
      begin
         case (s)
            `PXG_SIG_TXA: sig_is_output = 1'b1;
            `PXG_SIG_RXA: sig_is_output = mode0_a;
            `PXG_SIG_SDA: sig_is_output = 1'b1;
            `PXG_SIG_SCL: sig_is_output = 1'b1;
            `PXG_SIG_TXB: sig_is_output = 1'b1;
            `PXG_SIG_RXB: sig_is_output = mode0_b;
            `PXG_SIG_CMP1: sig_is_output = 1'b1;
            `PXG_SIG_SYSCLK: sig_is_output = 1'b1;
            default: sig_is_output = 1'b0;
         endcase
      end
   endfunction

   // Returns 1 for signals whose pins are always open-drain
   function sig_forced_od;
      input [4:0] s;
      input mode0_a;
      input mode0_b;
      begin
         case (s)
            `PXG_SIG_SDA: sig_forced_od = 1'b1;
            `PXG_SIG_SCL: sig_forced_od = 1'b1;
            `PXG_SIG_RXA: sig_forced_od = mode0_a;
            `PXG_SIG_RXB: sig_forced_od = mode0_b;
            default: sig_forced_od = 1'b0;
         endcase
      end
   endfunction

   // Merges a byte into a register under the low byte enable
   function [7:0] byte_merge;
      input [7:0] old;
      input [7:0] wdata;
      input en;
      begin
         byte_merge = en ? wdata : old;
      end
   endfunction

   // Picks the owner code of one pin from the flat owner vector
   function [4:0] owner_at;
      input [159:0] flat;
      input integer idx;
      begin
         owner_at = flat[idx*5 +: 5];
      end
   endfunction

   assign crossbar_global_enable = crossbar_config_two_reg[`PXG_XCFG2_GLOBAL_EN];
   assign data_flat = {data_reg[3], data_reg[2], data_reg[1], data_reg[0]};
   assign mode_flat = {mode_reg[3], mode_reg[2], mode_reg[1], mode_reg[0]};
   assign analog_pins = {16'h0000, ~port1_input_mode_reg, 8'h00};

   // Bus handshake: one wait cycle, then the access completes
   assign req = AVS_READ_I | AVS_WRITE_I;
   assign AVS_WAITREQUEST_O = req & ~ack_reg;
   assign AVS_READDATA_O = readdata_reg;
   assign wr_fire = AVS_WRITE_I & ack_reg;
   assign lane0 = AVS_BYTEENABLE_I[0];
   assign bit_pin = AVS_WRITEDATA_I[`PXG_BITACC_PIN_MSB:`PXG_BITACC_PIN_LSB];
   assign bit_port = bit_pin[4:3];
   assign bit_idx = bit_pin[2:0];

   assign PIN_O = pin_o_reg;
   assign PIN_OE_O = pin_oe_reg;
   assign PERIPH_IN_O = periph_in_reg;

   // Enabled signal groups in priority order
   always @* begin
      sig_en = 17'h00000;
      sig_en[0] = serial_enable_reg[`PXG_SERIAL_UART_A]; // see (RULE16)
      sig_en[1] = serial_enable_reg[`PXG_SERIAL_UART_A];
      sig_en[2] = serial_enable_reg[`PXG_SERIAL_TWI];
      sig_en[3] = serial_enable_reg[`PXG_SERIAL_TWI];
      sig_en[4] = crossbar_config_two_reg[`PXG_XCFG2_UART_B];
      sig_en[5] = crossbar_config_two_reg[`PXG_XCFG2_UART_B];
      sig_en[6] = crossbar_config_one_reg[`PXG_XCFG1_CMP1]; // see (RULE16)
      sig_en[7] = crossbar_config_one_reg[`PXG_XCFG1_TIMER0];
      sig_en[8] = crossbar_config_one_reg[`PXG_XCFG1_IRQ0];
      sig_en[9] = crossbar_config_one_reg[`PXG_XCFG1_TIMER1];
      sig_en[10] = crossbar_config_one_reg[`PXG_XCFG1_IRQ1];
      sig_en[11] = crossbar_config_one_reg[`PXG_XCFG1_TIMER2];
      sig_en[12] = crossbar_config_one_reg[`PXG_XCFG1_TIMER2_EXT];
      // Timer 4 signals sit after the timer 2 external input in priority
      sig_en[13] = crossbar_config_two_reg[`PXG_XCFG2_TIMER4];
      sig_en[14] = crossbar_config_two_reg[`PXG_XCFG2_TIMER4_EXT];
      sig_en[15] = crossbar_config_one_reg[`PXG_XCFG1_SYSCLK];
      sig_en[16] = crossbar_config_two_reg[`PXG_XCFG2_CONV_START]; // see (RULE16)
   end

   // Priority allocation: each free pin takes the next enabled signal
   always @* begin
      owner_flat = {32{`PXG_OWNER_NONE}};
      mapped = 32'h00000000;
      found = 1'b0;
      nxt = 0;
      for (p = 0; p < `PXG_NUM_PINS; p = p + 1) begin
         found = 1'b0;
         if (!analog_pins[p]) begin
            for (j = 0; j < `PXG_NUM_SIGS; j = j + 1) begin
               if (!found && j >= nxt && sig_en[j]) begin
                  found = 1'b1;
                  owner_flat[p*5 +: 5] = j[4:0]; // see (RULE15)
                  nxt = j + 1;
               end
            end
         end
         mapped[p] = found & crossbar_global_enable; // see (RULE5)
      end
   end

   // Per-pin peripheral direction, value and forced open-drain
   always @* begin
      periph_out_dir = 32'h00000000;
      periph_val = 32'h00000000;
      force_od = 32'h00000000;
      own = `PXG_OWNER_NONE;
      for (k = 0; k < `PXG_NUM_PINS; k = k + 1) begin
         own = owner_at(owner_flat, k);
         if (mapped[k]) begin
            periph_out_dir[k] = sig_is_output(own, UART_A_MODE0_I, UART_B_MODE0_I);
            periph_val[k] = PERIPH_OUT_I[own];
            force_od[k] = sig_forced_od(own, UART_A_MODE0_I, UART_B_MODE0_I); // see (RULE13)
         end
      end
   end

   // Routed peripheral inputs see the pin level; idle high when unrouted
   always @* begin
      periph_in_next = {17{1'b1}};
      for (m = 0; m < `PXG_NUM_PINS; m = m + 1) begin
         if (mapped[m] && !sig_is_output(owner_at(owner_flat, m), UART_A_MODE0_I,
                                         UART_B_MODE0_I)) begin
            periph_in_next[owner_at(owner_flat, m)] = PIN_I[m];
         end
      end
   end

   // Pin levels as software reads them; analog port 1 pins read 0
   always @* begin
      pin_read = PIN_I & ~analog_pins; // see (RULE3) see (RULE14)
   end

   pxg_pin_driver u_driver (
      .xbar_en_i(crossbar_global_enable),
      .data_i(data_flat),
      .mode_i(mode_flat),
      .mapped_i(mapped),
      .periph_out_i(periph_out_dir),
      .periph_val_i(periph_val),
      .force_od_i(force_od),
      .pin_val_o(drv_val),
      .pin_oe_o(drv_oe)
   );

   // Read data multiplexer
   always @* begin
      readdata_next = 32'h00000000;
      case (AVS_ADDRESS_I)
         `PXG_OFS_DATA0: readdata_next[7:0] = pin_read[7:0]; // see (RULE3)
         `PXG_OFS_DATA1: readdata_next[7:0] = pin_read[15:8];
         `PXG_OFS_DATA2: readdata_next[7:0] = pin_read[23:16];
         `PXG_OFS_DATA3: readdata_next[7:0] = pin_read[31:24];
         `PXG_OFS_MODE0: readdata_next[7:0] = mode_reg[0];
         `PXG_OFS_MODE1: readdata_next[7:0] = mode_reg[1];
         `PXG_OFS_MODE2: readdata_next[7:0] = mode_reg[2];
         `PXG_OFS_MODE3: readdata_next[7:0] = mode_reg[3];
         `PXG_OFS_P1IN: readdata_next[7:0] = port1_input_mode_reg;
         `PXG_OFS_SERIAL: readdata_next[7:0] = serial_enable_reg;
         `PXG_OFS_XCFG1: readdata_next[7:0] = crossbar_config_one_reg;
         `PXG_OFS_XCFG2: readdata_next[7:0] = crossbar_config_two_reg;
         `PXG_OFS_BITACC: readdata_next = pin_read; // see (RULE1)
         `PXG_OFS_LATCH0: readdata_next = data_flat; // see (RULE4)
         `PXG_OFS_LATCH1: readdata_next = mapped;
         `PXG_OFS_LATCH2: readdata_next = pin_oe_reg;
         default: readdata_next = 32'h00000000;
      endcase
   end

   always @* begin
      ack_next = req & ~ack_reg;
   end

   // Bus handshake and read data
   always @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ack_reg <= 1'b0;
         readdata_reg <= 32'h00000000;
      end else begin
         ack_reg <= ack_next;
         if (ack_next && AVS_READ_I) begin
            readdata_reg <= readdata_next;
         end
      end
   end

   // Configuration registers
   always @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         mode_reg[0] <= `PXG_RST_MODE; // see (RULE8)
         mode_reg[1] <= `PXG_RST_MODE;
         mode_reg[2] <= `PXG_RST_MODE;
         mode_reg[3] <= `PXG_RST_MODE;
         port1_input_mode_reg <= `PXG_RST_P1IN;
         serial_enable_reg <= `PXG_RST_CFG;
         crossbar_config_one_reg <= `PXG_RST_CFG;
         crossbar_config_two_reg <= `PXG_RST_CFG; // see (RULE6)
      end else if (wr_fire) begin
         case (AVS_ADDRESS_I)
            `PXG_OFS_MODE0: mode_reg[0] <= byte_merge(mode_reg[0], AVS_WRITEDATA_I[7:0], lane0);
            `PXG_OFS_MODE1: mode_reg[1] <= byte_merge(mode_reg[1], AVS_WRITEDATA_I[7:0], lane0);
            `PXG_OFS_MODE2: mode_reg[2] <= byte_merge(mode_reg[2], AVS_WRITEDATA_I[7:0], lane0);
            `PXG_OFS_MODE3: mode_reg[3] <= byte_merge(mode_reg[3], AVS_WRITEDATA_I[7:0], lane0);
            `PXG_OFS_P1IN: begin
               port1_input_mode_reg <= byte_merge(port1_input_mode_reg,
                                                  AVS_WRITEDATA_I[7:0], lane0);
            end
            `PXG_OFS_SERIAL: begin
               serial_enable_reg <= byte_merge(serial_enable_reg, AVS_WRITEDATA_I[7:0], lane0);
            end
            `PXG_OFS_XCFG1: begin
               crossbar_config_one_reg <= byte_merge(crossbar_config_one_reg,
                                                     AVS_WRITEDATA_I[7:0], lane0);
            end
            `PXG_OFS_XCFG2: begin
               crossbar_config_two_reg <= byte_merge(crossbar_config_two_reg,
                                                     AVS_WRITEDATA_I[7:0], lane0); // see (RULE5)
            end
            default: begin
               serial_enable_reg <= serial_enable_reg;
            end
         endcase
      end
   end

   // Port data registers: byte writes and single-bit writes
   always @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         data_reg[0] <= `PXG_RST_DATA;
         data_reg[1] <= `PXG_RST_DATA;
         data_reg[2] <= `PXG_RST_DATA;
         data_reg[3] <= `PXG_RST_DATA;
      end else if (wr_fire) begin
         case (AVS_ADDRESS_I)
            `PXG_OFS_DATA0: data_reg[0] <= byte_merge(data_reg[0], AVS_WRITEDATA_I[7:0], lane0); // see (RULE1)
            `PXG_OFS_DATA1: data_reg[1] <= byte_merge(data_reg[1], AVS_WRITEDATA_I[7:0], lane0);
            `PXG_OFS_DATA2: data_reg[2] <= byte_merge(data_reg[2], AVS_WRITEDATA_I[7:0], lane0);
            `PXG_OFS_DATA3: data_reg[3] <= byte_merge(data_reg[3], AVS_WRITEDATA_I[7:0], lane0);
            `PXG_OFS_BITACC: begin
               if (lane0) begin
                  data_reg[bit_port][bit_idx] <= AVS_WRITEDATA_I[`PXG_BITACC_VAL]; // see (RULE1)
               end
            end
            default: begin
               data_reg[0] <= data_reg[0];
            end
         endcase
      end
   end

   // Registered pin drive and routed peripheral inputs
   always @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         pin_o_reg <= 32'h00000000;
         pin_oe_reg <= 32'h00000000; // see (RULE6)
         periph_in_reg <= {17{1'b1}};
      end else begin
         pin_o_reg <= drv_val;
         pin_oe_reg <= drv_oe; // see (RULE6) see (RULE7)
         periph_in_reg <= periph_in_next;
      end
   end

endmodule // pxg_crossbar_gpio

// ---- hw/pxg_defines.vh ----
// Constants for the port crossbar and GPIO block
// What this block does
// (RULE1) Unallocated pins of ports 0-3 are GPIO through byte and bit access
// (RULE2) Allocated pins follow their peripheral; data register writes leave them unchanged
// (RULE3) Normal data register reads return the sampled pin levels
// (RULE4) Read-modify-write read phase returns the stored data register contents
// (RULE5) Software enables the crossbar after setup; assignments then take effect
// (RULE6) With the crossbar off, every output driver on ports 0-3 stays disabled
// (RULE7) Pins carrying peripheral inputs have their drivers disabled
// (RULE8) Pins support open-drain and push-pull and reset to open-drain
// (RULE9) Push-pull: data 0 drives low, data 1 drives high
// (RULE10) Open-drain: data 0 drives low, data 1 leaves the pin released
// (RULE11) Output mode bit 1 selects push-pull, 0 selects open-drain
// (RULE12) Output mode bits apply to GPIO and crossbar-allocated pins alike
// (RULE13) Serial data, serial clock and mode 0 UART receive pins are always open-drain
// (RULE14) Port 1 analog pins read as 0
// (RULE15) Signals take free pins in fixed priority from port 0 pin 0 upward
// (RULE16) A signal group joins allocation only when its enable bit is 1
`ifndef PXG_DEFINES_VH
`define PXG_DEFINES_VH

`define PXG_NUM_PINS 32
`define PXG_NUM_SIGS 17
`define PXG_NUM_PORTS 4
`define PXG_OWNER_NONE 5'h1f

// Register byte offsets
`define PXG_OFS_DATA0 6'h00
`define PXG_OFS_DATA1 6'h04
`define PXG_OFS_DATA2 6'h08
`define PXG_OFS_DATA3 6'h0c
`define PXG_OFS_MODE0 6'h10
`define PXG_OFS_MODE1 6'h14
`define PXG_OFS_MODE2 6'h18
`define PXG_OFS_MODE3 6'h1c
`define PXG_OFS_P1IN 6'h20
`define PXG_OFS_SERIAL 6'h24
`define PXG_OFS_XCFG1 6'h28
`define PXG_OFS_XCFG2 6'h2c
`define PXG_OFS_BITACC 6'h30
`define PXG_OFS_LATCH0 6'h34
`define PXG_OFS_LATCH1 6'h38
`define PXG_OFS_LATCH2 6'h3c

// Reset values
`define PXG_RST_DATA 8'hff
`define PXG_RST_MODE 8'h00
`define PXG_RST_P1IN 8'hff
`define PXG_RST_CFG 8'h00

// Field positions
`define PXG_XCFG2_GLOBAL_EN 6
`define PXG_XCFG2_CONV_START 0
`define PXG_XCFG2_UART_B 2
`define PXG_XCFG2_TIMER4 3
`define PXG_XCFG2_TIMER4_EXT 4
`define PXG_XCFG1_CMP1 0
`define PXG_XCFG1_TIMER0 1
`define PXG_XCFG1_IRQ0 2
`define PXG_XCFG1_TIMER1 3
`define PXG_XCFG1_IRQ1 4
`define PXG_XCFG1_TIMER2 5
`define PXG_XCFG1_TIMER2_EXT 6
`define PXG_XCFG1_SYSCLK 7
`define PXG_SERIAL_UART_A 0
`define PXG_SERIAL_TWI 1
`define PXG_BITACC_PIN_MSB 4
`define PXG_BITACC_PIN_LSB 0
`define PXG_BITACC_VAL 8
`define PXG_P1_LSB 8

// Signal indices in priority order
`define PXG_SIG_TXA 5'd0
`define PXG_SIG_RXA 5'd1
`define PXG_SIG_SDA 5'd2
`define PXG_SIG_SCL 5'd3
`define PXG_SIG_TXB 5'd4
`define PXG_SIG_RXB 5'd5
`define PXG_SIG_CMP1 5'd6
`define PXG_SIG_SYSCLK 5'd15

`endif

// ---- hw/pxg_pin_driver.v ----
// Per-pin output driver: mode, ownership and enable into pin level and enable
`timescale 1ns/1ps
module pxg_pin_driver (
   input wire xbar_en_i,
   input wire [31:0] data_i,
   input wire [31:0] mode_i,
   input wire [31:0] mapped_i,
   input wire [31:0] periph_out_i,
   input wire [31:0] periph_val_i,
   input wire [31:0] force_od_i,
   output wire [31:0] pin_val_o,
   output wire [31:0] pin_oe_o
);
   wire [31:0] drive_val;
   wire [31:0] is_input;
   wire [31:0] push_pull;

   // Allocated pins take the peripheral value, not the data register
   assign drive_val = (mapped_i & periph_val_i) | (~mapped_i & data_i); // see (RULE2)
   assign is_input = mapped_i & ~periph_out_i; // see (RULE7)
   // Mode bits act on all pins except forced open-drain ones
   assign push_pull = mode_i & ~force_od_i; // see (RULE11) see (RULE12) see (RULE13)
   // Push-pull drives both levels; open-drain drives only low
   assign pin_oe_o = {32{xbar_en_i}} & ~is_input & (push_pull | ~drive_val); // see (RULE6) see (RULE9) see (RULE10)
   assign pin_val_o = push_pull & drive_val; // see (RULE9) see (RULE10)

endmodule // pxg_pin_driver
